// ==== shared/pmx_pkg.sv ====
// constants and carrier types for the pin function multiplexer
package pmx_pkg;

    // ************************************************************
    // register addresses; the bus word address is the low byte of each
    // ************************************************************
    localparam logic [31:0] IDX_A_SEL    = 32'hFFFF_FC80;
    localparam logic [31:0] IDX_A_DIR    = 32'hFFFF_FC82;
    localparam logic [31:0] IDX_B_SEL_LO = 32'hFFFF_FC88;
    localparam logic [31:0] IDX_B_DIR    = 32'hFFFF_FC8A;
    localparam logic [31:0] IDX_B_SEL_HI = 32'hFFFF_FC8E;
    localparam int          ADDR_W       = 8;

    // ************************************************************
    // field layout and reset values
    // ************************************************************
    localparam logic [15:0] REG_RESET    = 16'h0000;
    localparam logic [15:0] A_SEL_MASK   = 16'h3FFF;
    localparam logic [15:0] A_DIR_MASK   = 16'h3FF7;
    localparam logic [15:0] FULL_MASK    = 16'hFFFF;
    localparam int          NUM_A        = 14;
    localparam int          NUM_B        = 16;
    localparam int          NUM_PIN      = 30;
    localparam int          NUM_SLOT     = 4;

    // bit k of nibble i set: slot k of pin i has a signal (B pins follow A)
    localparam logic [119:0] SLOT_MAP =
        120'h55_5FF7_7777_7777_7D33_3333_3333_3333;
    // set: the general port sits in slot 1 instead of slot 0
    localparam logic [29:0] PORT_IN_SLOT1 = 30'h0000_0080;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } pmx_avs_req_t;

    typedef struct packed {
        logic [NUM_SLOT-1:0] out;
        logic [NUM_SLOT-1:0] oe;
    } pmx_fn_t;

endpackage : pmx_pkg

// ==== design/pmx_mux.sv ====
// pin function multiplexer with its selection and direction registers
`timescale 1ns/1ps

// How it works
// - software registers pick each pin's function and port direction one by one; port A pin 3 stays input unless its slot 1 function drives it
// - no operating mode input exists, so nothing can override the selection
// - two-bit code per port B pin: 00 first, 01 second, 10 third, 11 fourth; port A one bit
// - port A pins 0..13 and port B pins 0..15 are multiplexed
// - after reset every pin uses its first function, code 00
// - after reset every port direction is input; only pin 7 may be driven, by its slot 0 function
// - five registers reset to zero, byte and halfword writes allowed
// - port A select bit n picks pin n function; bits 15,14 read 0
// - registers cleared only by power-on reset, kept otherwise
module pmx_mux (
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire pmx_pkg::pmx_avs_req_t avs_i,
    output logic [31:0]                avs_readdata_o,
    output logic                       avs_waitrequest_o,
    input  wire logic [29:0]           gpio_out_i,
    output logic [29:0]                gpio_in_o,
    input  wire pmx_pkg::pmx_fn_t [29:0] fn_drive_i,
    output logic [29:0][3:0]           fn_in_o,
    input  wire logic [29:0]           pin_in_i,
    output logic [29:0]                pin_out_o,
    output logic [29:0]                pin_oe_o
);

    // ************************************************************
    // register bus
    // ************************************************************
    logic [15:0] a_sel_q;
    logic [15:0] a_dir_q;
    logic [15:0] b_sel_lo_q;
    logic [15:0] b_dir_q;
    logic [15:0] b_sel_hi_q;
    logic        req;
    logic        wr_acc;
    logic [15:0] rd_d;

    localparam int ADDR_W_L = pmx_pkg::ADDR_W;

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic [15:0] mask);
        logic [15:0] r;
        r[7:0]  = be[0] ? wd[7:0]  : old[7:0];
        r[15:8] = be[1] ? wd[15:8] : old[15:8];
        return r & mask;
    endfunction : merge

    function automatic logic hit(input logic [ADDR_W_L-1:0] a,
                                 input logic [31:0] idx);
        return a == idx[ADDR_W_L-1:0];
    endfunction : hit

    assign req    = avs_i.read | avs_i.write;
    // a request completes at the edge where waitrequest is seen low
    assign wr_acc = avs_i.write & ~avs_waitrequest_o;

    always_comb
    begin
        rd_d = pmx_pkg::REG_RESET;
        if (hit(avs_i.address, pmx_pkg::IDX_A_SEL))
            rd_d = a_sel_q;
        else if (hit(avs_i.address, pmx_pkg::IDX_A_DIR))
            rd_d = a_dir_q;
        else if (hit(avs_i.address, pmx_pkg::IDX_B_SEL_LO))
            rd_d = b_sel_lo_q;
        else if (hit(avs_i.address, pmx_pkg::IDX_B_DIR))
            rd_d = b_dir_q;
        else if (hit(avs_i.address, pmx_pkg::IDX_B_SEL_HI))
            rd_d = b_sel_hi_q;
    end

    // one wait cycle per access; waitrequest idles high
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            avs_waitrequest_o <= 1'b1;
        else
            avs_waitrequest_o <= ~(req & avs_waitrequest_o);
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            avs_readdata_o <= 32'h0000_0000;
        else if (avs_i.read & avs_waitrequest_o)
            avs_readdata_o <= {16'h0000, rd_d};
    end

    // the only reset is power-on; nothing else touches these
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            a_sel_q    <= pmx_pkg::REG_RESET;
            a_dir_q    <= pmx_pkg::REG_RESET;
            b_sel_lo_q <= pmx_pkg::REG_RESET;
            b_dir_q    <= pmx_pkg::REG_RESET;
            b_sel_hi_q <= pmx_pkg::REG_RESET;
        end
        else if (wr_acc)
        begin
            if (hit(avs_i.address, pmx_pkg::IDX_A_SEL))
                a_sel_q <= merge(a_sel_q, avs_i.writedata,
                                 avs_i.byteenable, pmx_pkg::A_SEL_MASK);
            if (hit(avs_i.address, pmx_pkg::IDX_A_DIR))
                a_dir_q <= merge(a_dir_q, avs_i.writedata,
                                 avs_i.byteenable, pmx_pkg::A_DIR_MASK);
            if (hit(avs_i.address, pmx_pkg::IDX_B_SEL_LO))
                b_sel_lo_q <= merge(b_sel_lo_q, avs_i.writedata,
                                    avs_i.byteenable, pmx_pkg::FULL_MASK);
            if (hit(avs_i.address, pmx_pkg::IDX_B_DIR))
                b_dir_q <= merge(b_dir_q, avs_i.writedata,
                                 avs_i.byteenable, pmx_pkg::FULL_MASK);
            if (hit(avs_i.address, pmx_pkg::IDX_B_SEL_HI))
                b_sel_hi_q <= merge(b_sel_hi_q, avs_i.writedata,
                                    avs_i.byteenable, pmx_pkg::FULL_MASK);
        end
    end

    // ************************************************************
    // per-pin multiplexer
    // ************************************************************
    logic [29:0] sync1_q;
    logic [29:0] sync2_q;
    logic [29:0] dir_all;
    logic [31:0] b_code;

    assign dir_all = {b_dir_q, a_dir_q[13:0]};
    assign b_code  = {b_sel_hi_q, b_sel_lo_q};

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            sync1_q <= 30'h0000_0000;
            sync2_q <= 30'h0000_0000;
        end
        else
        begin
            sync1_q <= pin_in_i;
            sync2_q <= sync1_q;
        end
    end

    generate
        for (genvar i = 0; i < pmx_pkg::NUM_PIN; i++)
        begin : g_pin
            logic [1:0] code;
            logic [1:0] eff;
            logic [1:0] port_slot;
            logic [3:0] avail;

            // port A has one bit per pin, port B two
            if (i < pmx_pkg::NUM_A)
            begin : g_a
                assign code = {1'b0, a_sel_q[i]};
            end
            else
            begin : g_b
                assign code = b_code[2*(i-pmx_pkg::NUM_A) +: 2];
            end

            assign avail     = pmx_pkg::SLOT_MAP[4*i +: 4];
            assign port_slot = {1'b0, pmx_pkg::PORT_IN_SLOT1[i]};
            // only register bits steer the choice, no mode input
            // an empty slot falls back to the port function
            assign eff = avail[code] ? code : port_slot;

            always_ff @(posedge clk_i)
            begin
                if (!reset_n_i)
                begin
                    pin_out_o[i] <= 1'b0;
                    pin_oe_o[i]  <= 1'b0;
                    gpio_in_o[i] <= 1'b0;
                    fn_in_o[i]   <= 4'h0;
                end
                else
                begin
                    gpio_in_o[i] <= sync2_q[i];
                    if (eff == port_slot)
                    begin
                        pin_out_o[i] <= gpio_out_i[i];
                        pin_oe_o[i]  <= dir_all[i];
                        fn_in_o[i]   <= 4'h0;
                    end
                    else
                    begin
                        pin_out_o[i] <= fn_drive_i[i].out[eff];
                        pin_oe_o[i]  <= fn_drive_i[i].oe[eff];
                        fn_in_o[i]   <= {3'b000, sync2_q[i]} << eff;
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_req_wait;
        req && avs_waitrequest_o;
    endsequence

    sequence s_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    property p_handshake;
        s_req_wait |=> s_answer;
    endproperty
    a_handshake: assert property (p_handshake)
        else $error("request not answered after one wait cycle");

    property p_sel_reset;
        $rose(reset_n_i) |-> (a_sel_q == 16'h0000 && b_code == 32'h0);
    endproperty
    a_sel_reset: assert property (p_sel_reset)
        else $error("selection not cleared by reset");

    property p_oe_reset;
        $rose(reset_n_i) |-> pin_oe_o == 30'h0000_0000;
    endproperty
    a_oe_reset: assert property (p_oe_reset)
        else $error("pin driven right after reset");

    property p_byte_write;
        wr_acc && avs_i.byteenable == 4'h1
            && hit(avs_i.address, pmx_pkg::IDX_B_DIR)
            |=> b_dir_q == {$past(b_dir_q[15:8]),
                            $past(avs_i.writedata[7:0])};
    endproperty
    a_byte_write: assert property (p_byte_write)
        else $error("byte write disturbed the other byte");

    property p_a_reserved;
        a_sel_q[15:14] == 2'b00 && a_dir_q[15:14] == 2'b00
            && a_dir_q[3] == 1'b0;
    endproperty
    a_a_reserved: assert property (p_a_reserved)
        else $error("reserved bits of port A not zero");

    property p_hold;
        !wr_acc |=> $stable(a_sel_q) && $stable(a_dir_q)
            && $stable(b_code) && $stable(b_dir_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed without a write");

    property p_third_fn;
        b_code[25:24] == 2'b10 |=>
            pin_out_o[26] == $past(fn_drive_i[26].out[2]);
    endproperty
    a_third_fn: assert property (p_third_fn)
        else $error("third function not routed to pin");

    property p_empty_slot;
        b_code[31:30] == 2'b01 |=> pin_oe_o[29] == $past(b_dir_q[15]);
    endproperty
    a_empty_slot: assert property (p_empty_slot)
        else $error("empty slot did not fall back to port");

    property p_dir_write;
        wr_acc && avs_i.byteenable == 4'h3
            && hit(avs_i.address, pmx_pkg::IDX_A_DIR)
            |=> a_dir_q == ($past(avs_i.writedata[15:0]) & 16'h3FF7);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write not stored");

endmodule : pmx_mux

// ==== sim/pmx_far_side.sv ====
// far side model: peripheral drivers and the external pin wiring
`timescale 1ns/1ps
module pmx_far_side (
    input  wire logic [29:0]             ext_level_i,
    input  wire pmx_pkg::pmx_fn_t [29:0] periph_i,
    output pmx_pkg::pmx_fn_t [29:0]      fn_drive_o,
    input  wire logic [29:0]             pin_out_i,
    input  wire logic [29:0]             pin_oe_i,
    output logic [29:0]                  pin_level_o
);
    assign fn_drive_o = periph_i;
    // a driven pin reads its own level, an idle one the outside driver
    assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_level_i);
endmodule : pmx_far_side

// ==== sim/pin_function_mux_controller_bench.sv ====
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module pin_function_mux_controller_bench;
    logic                    clk_i     = 1'b0;
    logic                    reset_n_i = 1'b0;
    pmx_pkg::pmx_avs_req_t   avs       = '0;
    logic [31:0]             rdata;
    logic                    wait_req;
    logic [29:0]             gpio_out  = '0;
    logic [29:0]             ext_level = '0;
    pmx_pkg::pmx_fn_t [29:0] periph    = '0;
    pmx_pkg::pmx_fn_t [29:0] fn_drive;
    logic [29:0]             gpio_in;
    logic [29:0][3:0]        fn_in;
    logic [29:0]             pin_level;
    logic [29:0]             pin_out;
    logic [29:0]             pin_oe;
    logic [15:0]             regs [5];
    logic [7:0]              addr [5];
    logic [15:0]             mask [5];
    logic [31:0]             q;
    int                      r;
    int                      fail_count  = 0;
    int                      comparisons = 0;

    always #12.5 clk_i = ~clk_i;

    pmx_mux u_pmx_mux (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_i(avs),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
        .gpio_out_i(gpio_out), .gpio_in_o(gpio_in),
        .fn_drive_i(fn_drive), .fn_in_o(fn_in), .pin_in_i(pin_level),
        .pin_out_o(pin_out), .pin_oe_o(pin_oe)
    );
    pmx_far_side u_pmx_far_side (
        .ext_level_i(ext_level), .periph_i(periph), .fn_drive_o(fn_drive),
        .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin_level_o(pin_level)
    );

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input string what, input logic [119:0] exp,
                         input logic [119:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [15:0] d, input logic [1:0] be);
        logic [15:0] bm;
        bm = {{8{be[1]}}, {8{be[0]}}};
        @(posedge clk_i);
        avs <= '{a, !wr, wr, {16'h0000, d}, {2'b00, be}};
        // hold until waitrequest is seen low at a rising edge; a slave
        // that never answers is left to the watchdog
        do
        begin
            @(posedge clk_i);
        end
        while (wait_req !== 1'b0);
        q = rdata;
        avs.read  <= 1'b0;
        avs.write <= 1'b0;
        for (int i = 0; i < 5; i++)
            if (wr && a == addr[i])
                regs[i] = (regs[i] & ~bm) | (d & bm & mask[i]);
    endtask : bus

    task automatic read_check(input int k);
        bus(1'b0, addr[k], 16'h0000, 2'b11);
        check("register", 120'({16'h0000, regs[k]}), 120'(q));
    endtask : read_check

    task automatic shake;
        gpio_out  <= 30'($urandom);
        ext_level <= 30'($urandom);
        for (int i = 0; i < 30; i++)
            periph[i] <= 8'($urandom);
    endtask : shake

    task automatic check_pins;
        logic [29:0]      eo;
        logic [29:0]      ee;
        logic [29:0]      lv;
        logic [29:0][3:0] ef;
        int               k;
        // two sync flops and the output flop lie between pin and outputs
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        for (int i = 0; i < 30; i++)
        begin
            k = i < 14 ? int'(regs[0][i]) : i < 22 ?
                int'(regs[2][2*(i-14) +: 2]) : int'(regs[4][2*(i-22) +: 2]);
            if (k == int'(pmx_pkg::PORT_IN_SLOT1[i])
                || !pmx_pkg::SLOT_MAP[4*i+k])
                k = -1;
            eo[i] = k < 0 ? gpio_out[i] : periph[i].out[k];
            ee[i] = k >= 0 ? periph[i].oe[k] :
                    i < 14 ? regs[1][i] : regs[3][i-14];
            lv[i] = ee[i] ? eo[i] : ext_level[i];
            ef[i] = k < 0 ? 4'h0 : 4'(lv[i]) << k;
        end
        check("pin_out", 120'(eo), 120'(pin_out));
        check("pin_oe", 120'(ee), 120'(pin_oe));
        check("gpio_in", 120'(lv), 120'(gpio_in));
        check("fn_in", 120'(ef), 120'(fn_in));
    endtask : check_pins

    task automatic end_of_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    // ************************************************************
    // sequence
    // ************************************************************
    initial
    begin
        addr = '{8'h80, 8'h82, 8'h88, 8'h8A, 8'h8E};
        mask = '{pmx_pkg::A_SEL_MASK, pmx_pkg::A_DIR_MASK,
                 pmx_pkg::FULL_MASK, pmx_pkg::FULL_MASK, pmx_pkg::FULL_MASK};
        regs = '{default: pmx_pkg::REG_RESET};
        void'($urandom(32'h1eb4_275b));
        shake;
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        check_pins;
        for (int k = 0; k < 5; k++)
            read_check(k);
        bus(1'b0, 8'h84, 16'h0000, 2'b11);
        check("unmapped", 120'h0, 120'(q));
        for (int t = 0; t < 60; t++)
        begin
            r = $urandom_range(4);
            bus(1'b1, addr[r], 16'($urandom), 2'($urandom_range(3, 1)));
            read_check(r);
            shake;
            check_pins;
        end
        for (int k = 0; k < 5; k++)
        begin
            bus(1'b1, addr[k], 16'hFFFF, 2'b11);
            read_check(k);
        end
        bus(1'b1, 8'h84, 16'h0000, 2'b11);
        for (int k = 0; k < 5; k++)
            read_check(k);
        // every code on every port B pin at once, port A flipped alongside
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, addr[2], {8{2'(c)}}, 2'b11);
            bus(1'b1, addr[4], {8{2'(c)}}, 2'b11);
            bus(1'b1, addr[0], {16{c[0]}}, 2'b11);
            shake;
            check_pins;
        end
        // a second power-on reset in mid-run clears every selection
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        regs = '{default: pmx_pkg::REG_RESET};
        check_pins;
        for (int k = 0; k < 5; k++)
            read_check(k);
        end_of_test;
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        $display("ERROR watchdog expected done seen running");
        end_of_test;
    end
endmodule : pin_function_mux_controller_bench
